// ---- logic/compare_skip_decimal_adjust.sv ----
// Operation
// - A word whose top seven bits are 0110000 is compare-skip-if-less, with access flag and file address below.
// - The byte is compared with the accumulator by unsigned subtraction; skip when byte < accumulator, no write.
// - A taken skip discards the prefetched instruction and runs an idle cycle with four no-operation phases.
// - Each compare-skip is one word and takes one cycle, or two when the skip over a one-word instruction is taken.
// - A skip over a two-word instruction inserts two idle cycles, three cycles in total.
// - Access flag 0 takes the operand from the shared access bank, ignoring the bank select register.
// - Access flag 1 takes the operand bank from the bank select register.
// - Compare-skip decodes in Q1, reads the byte in Q2, compares in Q3 and writes nothing in Q4.
`default_nettype none
module compare_skip_decimal_adjust
  import compare_skip_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] instrWord,
  input  wire logic        nextTwoWord,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [7:0]  accIn,
  input  wire logic        carryIn,
  input  wire logic        digitCarryIn,
  input  wire logic [7:0]  memData,
  output var  phase_t      phase,
  output var  mem_req_t    memReq,
  output var  acc_wr_t     accWr,
  output var  logic        discardNext
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic op_t decodeOp(input logic [15:0] word);
    op_t result;
    result = OP_NONE;
    if (word[15:9] == LESS_PREFIX)
      result = OP_LESS;
    else if (word[15:9] == GREATER_PREFIX)
      result = OP_GREATER;
    else if (word == DECIMAL_WORD)
      result = OP_DECIMAL;
    return result;
  endfunction : decodeOp

  function automatic logic isCompare(input op_t o);
    return (o == OP_LESS) || (o == OP_GREATER);
  endfunction : isCompare

  function automatic logic [11:0] formAddr(input logic a, input logic [7:0] f, input logic [3:0] bank);
    logic [3:0] b;
    b = bank;
    if (!a)
      b = (f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK;
    return {b, f};
  endfunction : formAddr

  // returns {carry, value}
  function automatic logic [8:0] decimalAdjust(input logic [7:0] v, input logic digitCarry, input logic c);
    logic [8:0] t;
    logic [8:0] r;
    t = {1'b0, v};
    if (v[3:0] > BCD_LIMIT || digitCarry)
      t = t + LOW_ADJUST;
    r = t;
    if (t[7:4] > BCD_LIMIT || c || t[8])
      r = t + HIGH_ADJUST;
    return {c | t[8] | r[8], r[7:0]};
  endfunction : decimalAdjust

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  exec_state_t state;
  exec_state_t next_state;
  phase_t      next_phase;
  op_t         op;
  op_t         next_op;
  logic [7:0]  operand;
  logic [7:0]  next_operand;
  logic        skip;
  logic        next_skip;
  mem_req_t    next_memReq;
  acc_wr_t     next_accWr;
  logic        next_discardNext;
  logic [8:0]  difference;
  logic [8:0]  adjusted;

  assign difference = {1'b0, operand} - {1'b0, accIn};
  assign adjusted   = decimalAdjust(operand, digitCarryIn, carryIn);

  always_comb
  begin
    next_phase       = phase_t'(phase + 2'h1);
    next_state       = state;
    next_op          = op;
    next_operand     = operand;
    next_skip        = skip;
    next_memReq      = memReq;
    next_accWr       = accWr;
    next_discardNext = discardNext;
    case (phase)
      PH_Q1:
      begin
        if (state == ST_EXEC)
        begin
          next_op          = decodeOp(instrWord);
          next_memReq.addr = formAddr(instrWord[ACCESS_FLAG], instrWord[7:0], bankSelect);
          next_memReq.read = isCompare(decodeOp(instrWord));
        end
        else
        begin
          next_op          = OP_NONE;
          next_memReq.read = 1'b0;
        end
      end
      PH_Q2:
      begin
        next_memReq.read = 1'b0;
        if (isCompare(op))
          next_operand = memData;
        else if (op == OP_DECIMAL)
          next_operand = accIn;
      end
      PH_Q3:
      begin
        if (op == OP_LESS)
          next_skip = difference[8];
        else if (op == OP_GREATER)
          next_skip = !difference[8] && (difference[7:0] != 8'h00);
        else if (op == OP_DECIMAL)
        begin
          next_accWr.write = 1'b1;
          next_accWr.value = adjusted[7:0];
          next_accWr.carry = adjusted[8];
        end
      end
      PH_Q4:
      begin
        next_accWr.write = 1'b0;
        if (skip)
        begin
          next_skip        = 1'b0;
          next_op          = OP_NONE;
          next_discardNext = 1'b1;
          next_state       = nextTwoWord ? ST_FLUSH2 : ST_FLUSH1;
        end
        else
        begin
          case (state)
            ST_FLUSH2: next_state = ST_FLUSH1;
            ST_FLUSH1:
            begin
              next_state       = ST_EXEC;
              next_discardNext = 1'b0;
            end
            default:   next_state = ST_EXEC;
          endcase
        end
      end
      default: next_phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase       <= PH_Q1;
      state       <= ST_EXEC;
      op          <= OP_NONE;
      operand     <= 8'h00;
      skip        <= 1'b0;
      memReq      <= '0;
      accWr       <= '0;
      discardNext <= 1'b0;
    end
    else
    begin
      phase       <= next_phase;
      state       <= next_state;
      op          <= next_op;
      operand     <= next_operand;
      skip        <= next_skip;
      memReq      <= next_memReq;
      accWr       <= next_accWr;
      discardNext <= next_discardNext;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_less_decode: assert property (
    (phase == PH_Q1 && state == ST_EXEC && instrWord[15:9] == LESS_PREFIX) |=> (op == OP_LESS)
  ) else $error("less compare not decoded");

  a_less_skip: assert property (
    (phase == PH_Q3 && op == OP_LESS && operand < accIn) |=> skip ##1 discardNext
  ) else $error("less compare did not skip");

  a_compare_nowrite: assert property (
    isCompare(op) |-> !accWr.write
  ) else $error("compare wrote a result");

  a_skip_idle: assert property (
    (phase == PH_Q4 && skip) |=> (discardNext && op == OP_NONE && !memReq.read) [*4]
  ) else $error("skip idle cycle missing");

  a_noskip_single: assert property (
    (phase == PH_Q4 && !skip && state == ST_EXEC) |=> !discardNext
  ) else $error("no skip but cycle discarded");

  a_two_word_flush: assert property (
    (phase == PH_Q4 && skip && nextTwoWord) |=> discardNext [*8] ##1 !discardNext
  ) else $error("two word flush length wrong");

  a_access_bank: assert property (
    (phase == PH_Q1 && state == ST_EXEC && isCompare(decodeOp(instrWord)) && !instrWord[8])
      |=> memReq.addr[11:8] == (memReq.addr[7] ? ACCESS_HIGH_BANK : ACCESS_LOW_BANK)
  ) else $error("access bank not used");

  a_bank_select: assert property (
    (phase == PH_Q1 && state == ST_EXEC && isCompare(decodeOp(instrWord)) && instrWord[8])
      |=> memReq.read && memReq.addr[11:8] == $past(bankSelect)
  ) else $error("bank select not used");

  a_read_phase: assert property (
    memReq.read |-> phase == PH_Q2 && isCompare(op)
  ) else $error("read outside Q2");

  a_decimal_value: assert property (
    (phase == PH_Q2 && op == OP_DECIMAL)
      |-> ##2 accWr.write && {accWr.carry, accWr.value} == decimalAdjust($past(accIn, 2),
        $past(digitCarryIn, 1), $past(carryIn, 1))
  ) else $error("decimal adjust result wrong");

  a_write_phase: assert property (
    accWr.write |-> phase == PH_Q4 && op == OP_DECIMAL
  ) else $error("accumulator write outside Q4");

  c_less_skip:    cover property (phase == PH_Q4 && skip && op == OP_LESS && !nextTwoWord);
  c_greater_two:  cover property (phase == PH_Q4 && skip && op == OP_GREATER && nextTwoWord);
  c_decimal_done: cover property (accWr.write && accWr.carry);

endmodule : compare_skip_decimal_adjust
`default_nettype wire

// ---- pkg/compare_skip_pkg.sv ----
`default_nettype none
package compare_skip_pkg;

  // ----------------------------------------------------------------
  // instruction encodings
  // ----------------------------------------------------------------
  localparam logic [6:0]  LESS_PREFIX    = 7'h30;
  localparam logic [6:0]  GREATER_PREFIX = 7'h32;
  localparam logic [15:0] DECIMAL_WORD   = 16'h0007;
  localparam int          ACCESS_FLAG    = 8;

  // ----------------------------------------------------------------
  // addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCESS_SPLIT     = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // ----------------------------------------------------------------
  // decimal adjust constants
  // ----------------------------------------------------------------
  localparam logic [3:0] BCD_LIMIT  = 4'h9;
  localparam logic [8:0] LOW_ADJUST = 9'h006;
  localparam logic [8:0] HIGH_ADJUST = 9'h060;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    ST_EXEC   = 2'b00,
    ST_FLUSH1 = 2'b01,
    ST_FLUSH2 = 2'b10
  } exec_state_t;

  typedef enum logic [1:0] {
    OP_NONE    = 2'b00,
    OP_LESS    = 2'b01,
    OP_GREATER = 2'b10,
    OP_DECIMAL = 2'b11
  } op_t;

  typedef struct packed {
    logic        read;
    logic [11:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic       write;
    logic [7:0] value;
    logic       carry;
  } acc_wr_t;

endpackage : compare_skip_pkg
`default_nettype wire

// ---- tb/test_compare_skip_decimal_adjust.sv ----
`default_nettype none
module test_compare_skip_decimal_adjust
  import compare_skip_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [15:0] instrWord;
  logic        nextTwoWord;
  logic [3:0]  bankSelect;
  logic [7:0]  accIn;
  logic        carryIn;
  logic        digitCarryIn;
  logic [7:0]  memData;
  phase_t      phase;
  mem_req_t    memReq;
  acc_wr_t     accWr;
  logic        discardNext;
  int          n_mismatch;
  int          checked;

  compare_skip_decimal_adjust i_compare_skip_decimal_adjust (
    .clk          (clk),
    .rst_n        (rst_n),
    .instrWord    (instrWord),
    .nextTwoWord  (nextTwoWord),
    .bankSelect   (bankSelect),
    .accIn        (accIn),
    .carryIn      (carryIn),
    .digitCarryIn (digitCarryIn),
    .memData      (memData),
    .phase        (phase),
    .memReq       (memReq),
    .accWr        (accWr),
    .discardNext  (discardNext)
  );

  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step;
    @(posedge clk);
    #2;
  endtask : step

  task automatic wait_q1;
    int k;
    for (k = 0; k < 12 && !(phase === PH_Q1 && discardNext === 1'b0); k++)
      step;
    if (k == 12)
    begin
      n_mismatch++;
      print_verdict;
    end
  endtask : wait_q1

  // ----------------------------------------------------------------
  // one instruction, judged phase by phase
  // ----------------------------------------------------------------
  task automatic run(input logic [15:0] word, input logic [3:0] bsel, input logic [7:0] acc,
                     input logic [7:0] mem, input logic two, input logic c, input logic digitCarry,
                     input logic expRd, input logic [11:0] expAddr, input int expIdle,
                     input logic expWr, input logic [8:0] expAcc);
    int n;
    wait_q1;
    instrWord    = word;
    bankSelect   = bsel;
    accIn        = acc;
    memData      = mem;
    nextTwoWord  = two;
    carryIn      = c;
    digitCarryIn = digitCarry;
    step;
    instrWord = 16'h0000;
    check(memReq.read, expRd);
    if (expRd)
      check(memReq.addr, expAddr);
    step;
    check(memReq.read, 1'b0);
    step;
    check(accWr.write, expWr);
    if (expWr)
      check({accWr.value, accWr.carry}, expAcc);
    step;
    n = 0;
    while (discardNext === 1'b1 && n < 12)
    begin
      instrWord = DECIMAL_WORD;
      check({memReq.read, accWr.write}, 2'b00);
      n++;
      step;
    end
    instrWord = 16'h0000;
    check(16'(n), 16'(expIdle));
    if (n == 12)
    begin
      n_mismatch++;
      print_verdict;
    end
  endtask : run

  task automatic reset_in_idle;
    run(16'h6101, 4'h2, 8'h09, 8'h08, 1'b0, 1'b0, 1'b0, 1'b1, 12'h201, 4, 1'b0, 9'h000);
    wait_q1;
    instrWord = 16'h6101;
    repeat (4) step;
    instrWord = 16'h0000;
    check(discardNext, 1'b1);
    rst_n = 1'b0;
    #1;
    check({phase, discardNext, memReq.read, accWr.write}, 5'h00);
    step;
    rst_n = 1'b1;
  endtask : reset_in_idle

  initial
  begin
    clk          = 1'b0;
    rst_n        = 1'b0;
    instrWord    = 16'h0000;
    nextTwoWord  = 1'b0;
    bankSelect   = 4'h0;
    accIn        = 8'h00;
    carryIn      = 1'b0;
    digitCarryIn = 1'b0;
    memData      = 8'h00;
    n_mismatch   = 0;
    checked      = 0;
    repeat (8) @(posedge clk);
    #2;
    check({phase, discardNext}, 3'h0);
    rst_n = 1'b1;
    run(16'h617F, 4'h3, 8'h80, 8'h7F, 1'b0, 1'b0, 1'b0, 1'b1, 12'h37F, 4, 1'b0, 9'h000);
    run(16'h6090, 4'h5, 8'h44, 8'h44, 1'b1, 1'b0, 1'b0, 1'b1, 12'hF90, 0, 1'b0, 9'h000);
    run(16'h6001, 4'h7, 8'h02, 8'h01, 1'b1, 1'b0, 1'b0, 1'b1, 12'h001, 8, 1'b0, 9'h000);
    run(16'h6412, 4'h5, 8'h7F, 8'h80, 1'b1, 1'b0, 1'b0, 1'b1, 12'h012, 8, 1'b0, 9'h000);
    run(16'h65FF, 4'hA, 8'h20, 8'h10, 1'b0, 1'b1, 1'b1, 1'b1, 12'hAFF, 0, 1'b0, 9'h000);
    run(16'h6550, 4'hA, 8'h30, 8'h31, 1'b0, 1'b0, 1'b0, 1'b1, 12'hA50, 4, 1'b0, 9'h000);
    run(16'h6600, 4'h1, 8'h00, 8'hFF, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 0, 1'b0, 9'h000);
    run(DECIMAL_WORD, 4'h0, 8'hA5, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 0, 1'b1, 9'h00B);
    run(DECIMAL_WORD, 4'h0, 8'hCE, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 12'h000, 0, 1'b1, 9'h069);
    run(DECIMAL_WORD, 4'h0, 8'h19, 8'h00, 1'b0, 1'b0, 1'b1, 1'b0, 12'h000, 0, 1'b1, 9'h03E);
    run(DECIMAL_WORD, 4'h0, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 12'h000, 0, 1'b1, 9'h0C1);
    reset_in_idle;
    run(16'h6040, 4'h9, 8'h41, 8'h40, 1'b0, 1'b0, 1'b0, 1'b1, 12'h040, 4, 1'b0, 9'h000);
    print_verdict;
  end
endmodule : test_compare_skip_decimal_adjust
`default_nettype wire
